// [rtl/vhsi_pkg.sv]
// vhsi_pkg: shared constants for the valve head status indication block
package vhsi_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_FREQ_HZ / 1000;
   localparam int unsigned WDOG_TIME_MS  = 50;
   localparam int unsigned WDOG_CYCLES   = WDOG_TIME_MS * CYC_PER_MS;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned FLASH_CYCLES  = FLASH_HALF_MS * CYC_PER_MS;
   localparam int unsigned CNT_W         = 32;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_INT_STAT = 8'h08;
   localparam logic [7:0] REG_INT_MASK = 8'h0C;

   // ************************************************************
   // control fields and reset values
   // ************************************************************
   localparam int unsigned CTRL_BUS_VARIANT  = 0;
   localparam int unsigned CTRL_CONTROL_HEAD = 1;
   localparam logic [1:0]  CTRL_RESET        = 2'h3;

   // ************************************************************
   // status fields
   // ************************************************************
   localparam int unsigned ST_POS_LSB    = 0;
   localparam int unsigned ST_VALVE_LSB  = 4;
   localparam int unsigned ST_WDOG       = 6;
   localparam int unsigned ST_BUS_GREEN  = 7;
   localparam int unsigned ST_BUS_RED    = 8;
   localparam int unsigned ST_ADDR_ZERO  = 9;
   localparam int unsigned ST_COLOUR_BAD = 10;
   localparam int unsigned ST_SIZE_BAD   = 11;

   // ************************************************************
   // interrupt event bits
   // ************************************************************
   localparam int unsigned IRQ_W          = 5;
   localparam int unsigned EV_WDOG        = 0;
   localparam int unsigned EV_ADDR_ZERO   = 1;
   localparam int unsigned EV_COLOUR_BAD  = 2;
   localparam int unsigned EV_SIZE_BAD    = 3;
   localparam int unsigned EV_POS_CHANGE  = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

   // ************************************************************
   // actuator size selector positions and colour switch codes
   // ************************************************************
   localparam int unsigned SIZE_N                = 3;
   localparam int unsigned SMALL_ACTUATOR_SIZE   = 0;
   localparam int unsigned MEDIUM_ACTUATOR_SIZE  = 1;
   localparam int unsigned LARGE_ACTUATOR_SIZE   = 2;
   localparam logic [1:0]  COLOUR_BOTH_UP        = 2'h3;
   localparam logic [1:0]  COLOUR_BOTH_DOWN      = 2'h0;

   localparam int unsigned ADDR_W = 5;

endpackage : vhsi_pkg

// [rtl/vhsi_sync.sv]
// vhsi_sync: two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module vhsi_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : vhsi_sync
`default_nettype wire

// [rtl/vhsi_chan.sv]
// vhsi_chan: end-position detection and colour display for one actuator chamber
`timescale 1ns/1ps
`default_nettype none
module vhsi_chan (
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // synchronised switches and sensors
   input  wire logic [vhsi_pkg::SIZE_N-1:0] size_sel,
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_top,
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_bot,
   input  wire logic [1:0]                colour_sw,
   // detection result
   output logic                           pos_top_ff,
   output logic                           pos_bot_ff,
   // display
   output logic                           led_green_ff,
   output logic                           led_yellow_ff,
   // setting faults
   output logic                           colour_bad_ff,
   output logic                           size_bad_ff
);
   import vhsi_pkg::*;

   logic nxt_top;
   logic nxt_bot;
   logic nxt_green;
   logic nxt_yellow;
   logic one_hot;

   always_comb begin
      // only the sensors of the selected size are enabled
      nxt_top = |(size_sel & sens_top);
      nxt_bot = |(size_sel & sens_bot);
      one_hot = (size_sel == 3'h1) || (size_sel == 3'h2) || (size_sel == 3'h4);
      case (colour_sw)
         COLOUR_BOTH_UP: begin
            nxt_yellow = nxt_top;
            nxt_green  = nxt_bot;
         end
         COLOUR_BOTH_DOWN: begin
            nxt_green  = nxt_top;
            nxt_yellow = nxt_bot;
         end
         default: begin
            // invalid pair darkens the colours only, detection untouched
            nxt_green  = 1'b0;
            nxt_yellow = 1'b0;
         end
      endcase
   end

   // detection outputs are computed apart from the colour choice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_top_ff <= 1'b0;
         pos_bot_ff <= 1'b0;
      end else begin
         pos_top_ff <= nxt_top;
         pos_bot_ff <= nxt_bot;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_green_ff  <= 1'b0;
         led_yellow_ff <= 1'b0;
      end else begin
         led_green_ff  <= nxt_green;
         led_yellow_ff <= nxt_yellow;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         colour_bad_ff <= 1'b0;
         size_bad_ff   <= 1'b0;
      end else begin
         colour_bad_ff <= (colour_sw != COLOUR_BOTH_UP) && (colour_sw != COLOUR_BOTH_DOWN);
         size_bad_ff   <= !one_hot;
      end
   end
endmodule : vhsi_chan
`default_nettype wire

// [rtl/vhsi_top.sv]
// vhsi_top: bus status, end-position display and pilot valve control of a valve head
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - green on red off when bus ok
// - watchdog expired, nonzero address: red only
// - address zero: green flashes, red lit
// - non-bus variant: both bus indicators dark
// - two independent chamber channels
// - size selector enables only matching sensors
// - both colour switches up: top yellow
// - both colour switches down: top green
// - bad colour pair darkens the display and raises colour_bad, detection untouched
// - service switch energises valve regardless of bus command, while the control head bit is set
// - report bits 0..3, command bits 0..1
module vhsi_top #(
   parameter int unsigned WDOG_CYC  = vhsi_pkg::WDOG_CYCLES,
   parameter int unsigned FLASH_CYC = vhsi_pkg::FLASH_CYCLES
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // field bus slave logic
   input  wire logic                        bus_frame,
   input  wire logic [vhsi_pkg::ADDR_W-1:0] bus_slave_addr,
   input  wire logic [1:0]                  bus_valve_cmd,
   output logic      [3:0]                  bus_report,
   // pins: end-position sensors, chamber one
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_top_1,
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_bot_1,
   // pins: end-position sensors, chamber two
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_top_2,
   input  wire logic [vhsi_pkg::SIZE_N-1:0] sens_bot_2,
   // pins: switches
   input  wire logic [vhsi_pkg::SIZE_N-1:0] size_sw_1,
   input  wire logic [vhsi_pkg::SIZE_N-1:0] size_sw_2,
   input  wire logic [1:0]                  colour_sw_1,
   input  wire logic [1:0]                  colour_sw_2,
   input  wire logic [1:0]                  service_sw,
   // bus status indicators
   output logic                             led_bus_green,
   output logic                             led_bus_red,
   // end-position indicators
   output logic                             led_green_1,
   output logic                             led_yellow_1,
   output logic                             led_green_2,
   output logic                             led_yellow_2,
   // pilot valves and their indicators
   output logic                             first_pilot_valve,
   output logic                             second_pilot_valve,
   output logic                             led_valve_1,
   output logic                             led_valve_2,
   // interrupt
   output logic                             irq
);
   import vhsi_pkg::*;

   // ************************************************************
   // pin synchronisation
   // ************************************************************
   localparam int unsigned PIN_W = 4 * SIZE_N + 2 * SIZE_N + 6;

   logic [PIN_W-1:0]  pins_sync;
   logic [SIZE_N-1:0] s_top_1;
   logic [SIZE_N-1:0] s_bot_1;
   logic [SIZE_N-1:0] s_top_2;
   logic [SIZE_N-1:0] s_bot_2;
   logic [SIZE_N-1:0] s_size_1;
   logic [SIZE_N-1:0] s_size_2;
   logic [1:0]        s_colour_1;
   logic [1:0]        s_colour_2;
   logic [1:0]        s_service;

   vhsi_sync #(
      .WIDTH    (PIN_W)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({sens_top_1, sens_bot_1, sens_top_2, sens_bot_2, size_sw_1, size_sw_2,
                  colour_sw_1, colour_sw_2, service_sw}),
      .sync_out (pins_sync)
   );

   assign {s_top_1, s_bot_1, s_top_2, s_bot_2, s_size_1, s_size_2,
           s_colour_1, s_colour_2, s_service} = pins_sync;

   // ************************************************************
   // chamber channels
   // ************************************************************
   logic pos_top_1;
   logic pos_bot_1;
   logic pos_top_2;
   logic pos_bot_2;
   logic colour_bad_1;
   logic colour_bad_2;
   logic size_bad_1;
   logic size_bad_2;

   // one channel per chamber, sharing nothing
   vhsi_chan u_chan_1 (
      .pclk          (pclk),
      .presetn       (presetn),
      .size_sel      (s_size_1),
      .sens_top      (s_top_1),
      .sens_bot      (s_bot_1),
      .colour_sw     (s_colour_1),
      .pos_top_ff    (pos_top_1),
      .pos_bot_ff    (pos_bot_1),
      .led_green_ff  (led_green_1),
      .led_yellow_ff (led_yellow_1),
      .colour_bad_ff (colour_bad_1),
      .size_bad_ff   (size_bad_1)
   );

   vhsi_chan u_chan_2 (
      .pclk          (pclk),
      .presetn       (presetn),
      .size_sel      (s_size_2),
      .sens_top      (s_top_2),
      .sens_bot      (s_bot_2),
      .colour_sw     (s_colour_2),
      .pos_top_ff    (pos_top_2),
      .pos_bot_ff    (pos_bot_2),
      .led_green_ff  (led_green_2),
      .led_yellow_ff (led_yellow_2),
      .colour_bad_ff (colour_bad_2),
      .size_bad_ff   (size_bad_2)
   );

   // ************************************************************
   // control register and apb decode
   // ************************************************************
   logic [1:0]       ctrl_ff;
   logic [IRQ_W-1:0] int_stat_ff;
   logic [IRQ_W-1:0] int_mask_ff;
   logic [31:0]      status;
   logic [31:0]      nxt_prdata;
   logic             nxt_err;
   logic             wr_en;
   logic             setup;
   logic             bus_on;
   logic             ctl_head;

   assign setup    = psel && !penable;
   assign wr_en    = psel && penable && pready && pwrite && !pslverr;
   assign bus_on   = ctrl_ff[CTRL_BUS_VARIANT];
   assign ctl_head = ctrl_ff[CTRL_CONTROL_HEAD];

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_err    = 1'b0;
      case (paddr)
         REG_CTRL:     nxt_prdata = {30'h0000_0000, ctrl_ff};
         REG_STATUS:   nxt_prdata = status;
         REG_INT_STAT: nxt_prdata = {27'h000_0000, int_stat_ff};
         REG_INT_MASK: nxt_prdata = {27'h000_0000, int_mask_ff};
         default:      nxt_err    = 1'b1;
      endcase
   end

   // answer is prepared in the setup cycle, so access ends after one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && nxt_err;
         if (setup && !pwrite) begin
            prdata <= nxt_prdata;
         end else if (setup) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_en && paddr == REG_CTRL) begin
         ctrl_ff <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_ff <= IRQ_RESET;
      end else if (wr_en && paddr == REG_INT_MASK) begin
         int_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   // ************************************************************
   // communication watchdog
   // ************************************************************
   logic [CNT_W-1:0] wdog_cnt_ff;
   logic             wdog_exp_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_cnt_ff <= '0;
         wdog_exp_ff <= 1'b0;
      end else if (bus_frame) begin
         wdog_cnt_ff <= '0;
         wdog_exp_ff <= 1'b0;
      end else if (wdog_cnt_ff == CNT_W'(WDOG_CYC - 1)) begin
         wdog_exp_ff <= 1'b1;
      end else begin
         wdog_cnt_ff <= wdog_cnt_ff + CNT_W'(1);
      end
   end

   // ************************************************************
   // flash divider
   // ************************************************************
   logic [CNT_W-1:0] flash_cnt_ff;
   logic             flash_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_ff <= '0;
         flash_ff     <= 1'b0;
      end else if (flash_cnt_ff == CNT_W'(FLASH_CYC - 1)) begin
         flash_cnt_ff <= '0;
         flash_ff     <= !flash_ff;
      end else begin
         flash_cnt_ff <= flash_cnt_ff + CNT_W'(1);
      end
   end

   // ************************************************************
   // bus status indicators
   // ************************************************************
   logic addr_zero;

   assign addr_zero = (bus_slave_addr == '0);

   // reset stands for the unpowered state: both dark
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_bus_green <= 1'b0;
         led_bus_red   <= 1'b0;
      end else if (!bus_on) begin
         led_bus_green <= 1'b0;
         led_bus_red   <= 1'b0;
      end else if (addr_zero) begin
         led_bus_green <= flash_ff;
         led_bus_red   <= 1'b1;
      end else if (wdog_exp_ff) begin
         led_bus_green <= 1'b0;
         led_bus_red   <= 1'b1;
      end else begin
         led_bus_green <= 1'b1;
         led_bus_red   <= 1'b0;
      end
   end

   // ************************************************************
   // pilot valves and bus report
   // ************************************************************
   logic [1:0] cmd;
   logic [1:0] valve;

   // bus commands are dropped while the watchdog has expired in the bus variant
   assign cmd   = (bus_on && wdog_exp_ff) ? 2'h0 : bus_valve_cmd;
   assign valve = ctl_head ? (cmd | s_service) : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_pilot_valve  <= 1'b0;
         second_pilot_valve <= 1'b0;
         led_valve_1        <= 1'b0;
         led_valve_2        <= 1'b0;
      end else begin
         first_pilot_valve  <= valve[0];
         second_pilot_valve <= valve[1];
         led_valve_1        <= valve[0];
         led_valve_2        <= valve[1];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_report <= 4'h0;
      end else begin
         bus_report <= {pos_bot_2, pos_top_2, pos_bot_1, pos_top_1};
      end
   end

   // ************************************************************
   // status and interrupts
   // ************************************************************
   logic             colour_bad;
   logic             size_bad;
   logic             prev_wdog_ff;
   logic             prev_azero_ff;
   logic             prev_cbad_ff;
   logic             prev_sbad_ff;
   logic [3:0]       prev_pos_ff;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] clr;

   assign colour_bad = colour_bad_1 || colour_bad_2;
   assign size_bad   = size_bad_1 || size_bad_2 || (s_size_1 != s_size_2);

   always_comb begin
      status = 32'h0000_0000;
      status[ST_POS_LSB +: 4]   = bus_report;
      status[ST_VALVE_LSB +: 2] = {second_pilot_valve, first_pilot_valve};
      status[ST_WDOG]           = wdog_exp_ff;
      status[ST_BUS_GREEN]      = led_bus_green;
      status[ST_BUS_RED]        = led_bus_red;
      status[ST_ADDR_ZERO]      = addr_zero;
      status[ST_COLOUR_BAD]     = colour_bad;
      status[ST_SIZE_BAD]       = size_bad;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_wdog_ff  <= 1'b0;
         prev_azero_ff <= 1'b0;
         prev_cbad_ff  <= 1'b0;
         prev_sbad_ff  <= 1'b0;
         prev_pos_ff   <= 4'h0;
      end else begin
         prev_wdog_ff  <= wdog_exp_ff;
         prev_azero_ff <= addr_zero;
         prev_cbad_ff  <= colour_bad;
         prev_sbad_ff  <= size_bad;
         prev_pos_ff   <= bus_report;
      end
   end

   always_comb begin
      events = '0;
      events[EV_WDOG]       = wdog_exp_ff && !prev_wdog_ff;
      events[EV_ADDR_ZERO]  = addr_zero && !prev_azero_ff;
      events[EV_COLOUR_BAD] = colour_bad && !prev_cbad_ff;
      events[EV_SIZE_BAD]   = size_bad && !prev_sbad_ff;
      events[EV_POS_CHANGE] = bus_report != prev_pos_ff;
   end

   assign clr = (wr_en && paddr == REG_INT_STAT) ? pwdata[IRQ_W-1:0] : '0;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_ff <= IRQ_RESET;
      end else begin
         int_stat_ff <= (int_stat_ff & ~clr) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_ff & int_mask_ff);
      end
   end

endmodule : vhsi_top
`default_nettype wire

// [verif/vhsi_bus_master.sv]
// vhsi_bus_master: field bus master model issuing periodic frames
`timescale 1ns/1ps
`default_nettype none
module vhsi_bus_master (
   // clock, reset and bench control
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   // frame strobe towards the slave logic
   output logic      bus_frame
);
   logic [2:0] gap_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff    <= 3'h0;
         bus_frame <= 1'b0;
      end else begin
         gap_ff    <= run ? gap_ff + 3'h1 : 3'h0;
         bus_frame <= run && gap_ff == 3'h4;
      end
   end
endmodule : vhsi_bus_master
`default_nettype wire

// [verif/vhsi_top_assertions.sv]
// vhsi_top_assertions: port-level checks of the valve head block
`timescale 1ns/1ps
`default_nettype none
module vhsi_top_assertions #(
   parameter int unsigned WDOG_CYC  = 20,
   parameter int unsigned FLASH_CYC = 8
) (
   // clock, reset and apb writes
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   // field bus and pins
   input wire logic        bus_frame,
   input wire logic [4:0]  bus_slave_addr,
   input wire logic [3:0]  bus_report,
   input wire logic [1:0]  colour_sw_1,
   input wire logic [1:0]  service_sw,
   // indicators and valve
   input wire logic        led_bus_green,
   input wire logic        led_bus_red,
   input wire logic        led_green_1,
   input wire logic        led_yellow_1,
   input wire logic        first_pilot_valve
);
   import vhsi_pkg::*;
   logic [1:0]  ctrl_ff;
   int unsigned idle_ff;
   // mirror of the control word and cycles since the last frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
         idle_ff <= 0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == REG_CTRL)
            ctrl_ff <= pwdata[1:0];
         idle_ff <= bus_frame ? 0 : idle_ff + 1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_bus_ok_green: assert property (bus_frame && bus_slave_addr != 5'h00 && ctrl_ff[0]
      ##1 bus_slave_addr != 5'h00 && ctrl_ff[0] |=> led_bus_green && !led_bus_red)
      else $error("bus ok state not shown");
   a_wdog_red_only: assert property (idle_ff >= WDOG_CYC + 2 && $past(ctrl_ff[0])
      && $past(bus_slave_addr) != 5'h00 |-> led_bus_red && !led_bus_green)
      else $error("expired watchdog not shown");
   a_addr_zero_red: assert property ($past(presetn) && $past(ctrl_ff[0])
      && $past(bus_slave_addr) == 5'h00 |-> led_bus_red) else $error("red dark at address 0");
   a_variant_dark: assert property (!$past(ctrl_ff[0])
      |-> !led_bus_green && !led_bus_red) else $error("bus leds lit without bus");
   a_colour_up_map: assert property ($past(colour_sw_1, 4) == 2'h3
      |-> bus_report[1:0] == {$past(led_green_1), $past(led_yellow_1)})
      else $error("colour up mapping wrong");
   a_colour_dn_map: assert property ($past(colour_sw_1, 4) == 2'h0
      |-> bus_report[1:0] == {$past(led_yellow_1), $past(led_green_1)})
      else $error("colour down mapping wrong");
   a_colour_bad_dark: assert property ($past(colour_sw_1, 3) inside {2'h1, 2'h2}
      |-> !led_green_1 && !led_yellow_1) else $error("colour leds lit on bad pair");
   a_service_valve: assert property ($past(service_sw[0], 3) && $past(ctrl_ff[1])
      |-> first_pilot_valve) else $error("service switch ignored");
endmodule : vhsi_top_assertions
bind vhsi_top vhsi_top_assertions #(.WDOG_CYC(WDOG_CYC), .FLASH_CYC(FLASH_CYC)) i_chk (
   .pclk              (pclk),
   .presetn           (presetn),
   .psel              (psel),
   .penable           (penable),
   .pwrite            (pwrite),
   .pready            (pready),
   .paddr             (paddr),
   .pwdata            (pwdata),
   .bus_frame         (bus_frame),
   .bus_slave_addr    (bus_slave_addr),
   .bus_report        (bus_report),
   .colour_sw_1       (colour_sw_1),
   .service_sw        (service_sw),
   .led_bus_green     (led_bus_green),
   .led_bus_red       (led_bus_red),
   .led_green_1       (led_green_1),
   .led_yellow_1      (led_yellow_1),
   .first_pilot_valve (first_pilot_valve)
);
`default_nettype wire

// [verif/tb_valve_head_status_indication.sv]
// tb_valve_head_status_indication: directed bench for the valve head block
`timescale 1ns/1ps
`default_nettype none
module tb_valve_head_status_indication;
   import vhsi_pkg::*;
   localparam int unsigned W = 20;
   localparam int unsigned F = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_frame, run, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [ADDR_W-1:0] bus_slave_addr;
   logic [1:0]  bus_valve_cmd, colour_sw_1, colour_sw_2, service_sw;
   logic [3:0]  bus_report;
   logic [SIZE_N-1:0] sens_top_1, sens_bot_1, sens_top_2, sens_bot_2, size_sw_1, size_sw_2;
   logic        led_bus_green, led_bus_red, led_green_1, led_yellow_1, led_green_2, led_yellow_2;
   logic        first_pilot_valve, second_pilot_valve, led_valve_1, led_valve_2, err;
   int          bad_count, comparisons, n;
   vhsi_top #(.WDOG_CYC(W), .FLASH_CYC(F)) i_dut (.*);
   vhsi_bus_master i_master (.pclk, .presetn, .run, .bus_frame);
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask : cyc
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", s, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic report_and_stop();
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      cyc(2000);
      bad_count++;
      report_and_stop();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, run, service_sw, bus_valve_cmd} = '0;
      {paddr, pwdata, sens_top_1, sens_bot_1, sens_top_2, sens_bot_2} = '0;
      {size_sw_1, size_sw_2, colour_sw_1, colour_sw_2} = 10'h09F;
      bus_slave_addr = 5'h05;
      cyc(10);
      presetn <= 1'b1;
      run     <= 1'b1;
      cyc(12);
      chk("bus green", 1, led_bus_green);
      chk("bus red", 0, led_bus_red);
      run <= 1'b0;
      cyc(W + 4);
      chk("bus green", 0, led_bus_green);
      chk("bus red", 1, led_bus_red);
      bus_slave_addr <= 5'h00;
      run            <= 1'b1;
      cyc(3);
      n = 0;
      repeat (2 * F + 2) begin
         @(posedge pclk);
         n += led_bus_green;
      end
      chk("flash count", 1, n >= F && n <= F + 2);
      chk("bus red", 1, led_bus_red);
      apb(0, REG_INT_STAT, 0);
      chk("int stat", 32'h3, rd & 32'h3);
      chk("irq masked", 0, irq);
      apb(1, REG_INT_MASK, 32'h2);
      cyc(2);
      chk("irq", 1, irq);
      apb(1, REG_INT_STAT, 32'h1F);
      cyc(2);
      chk("irq", 0, irq);
      apb(0, 8'h10, 0);
      chk("unmapped err", 1, err);
      bus_slave_addr <= 5'h05;
      apb(1, REG_CTRL, 32'h2);
      cyc(3);
      chk("bus green", 0, led_bus_green);
      chk("bus red", 0, led_bus_red);
      apb(0, REG_CTRL, 0);
      chk("ctrl", 32'h2, rd);
      apb(1, REG_CTRL, 32'h3);
      sens_top_1 <= 3'h1;
      sens_bot_2 <= 3'h2;
      for (int c = 0; c < 4; c++) begin
         colour_sw_1 <= 2'(c);
         cyc(6);
         chk("green one", c == 0, led_green_1);
         chk("yellow one", c == 3, led_yellow_1);
         chk("report", 4'h1, bus_report);
         chk("green two", 0, led_green_2);
      end
      {size_sw_1, size_sw_2} <= 6'h12;
      cyc(6);
      chk("report", 4'h8, bus_report);
      chk("green two", 1, led_green_2);
      chk("yellow one", 0, led_yellow_1);
      chk("yellow two", 0, led_yellow_2);
      service_sw <= 2'h1;
      cyc(5);
      chk("valves", 2'h1, {second_pilot_valve, first_pilot_valve});
      chk("valve leds", 2'h1, {led_valve_2, led_valve_1});
      bus_valve_cmd <= 2'h2;
      cyc(3);
      chk("valves", 2'h3, {second_pilot_valve, first_pilot_valve});
      apb(0, REG_STATUS, 0);
      chk("status", 32'h0000_00B8, rd);
      report_and_stop();
   end
endmodule : tb_valve_head_status_indication
`default_nettype wire
